/* File: fsp_pkg.sv */
// Package for the status register and block-protect logic of a serial flash.
// Assumes a 100 MHz core clock; every cycle count below is derived from it.
package fsp_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Cycle times are plain defaults and not device figures.
   localparam int STATUS_WRITE_NS = 2000;
   localparam int PROGRAM_NS = 5000;
   localparam int ERASE_NS = 20000;
   localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROGRAM_CYC = (PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_CYC = (ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   localparam int SR_WD_BIT = 7;
   localparam int SR_BP3_BIT = 6;
   localparam int SR_TB_BIT = 5;
   localparam int SR_BPLO_MSB = 4;
   localparam int SR_BPLO_LSB = 2;
   localparam int SR_WEL_BIT = 1;
   localparam int SR_WIP_BIT = 0;
   localparam int FL_READY_BIT = 7;
   localparam int FL_PROT_BIT = 1;

   localparam logic SR_WD_RST = 1'h1;
   localparam logic SR_TB_RST = 1'h1;
   localparam logic [3:0] BP_RST = 4'h0;

   localparam int ADDR_W = 28;
   localparam int SECTOR_MSB = 27;
   localparam int SECTOR_LSB = 16;
   localparam int SUB32_LSB = 15;
   localparam int SUB4_LSB = 12;
   localparam logic [12:0] SECTOR_COUNT = 13'h1000;
   localparam logic [12:0] TOP_BASE_SPAN = 13'h0008;
   localparam logic [3:0] BP_ZERO = 4'h0;
   localparam logic [3:0] BP_ONE = 4'h1;
   localparam logic [3:0] BP_TOP_FIRST = 4'h4;
   localparam logic [3:0] BP_ALL_FIRST = 4'hD;

   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_WR_ENABLE = 4'h1,
      CMD_WR_DISABLE = 4'h2,
      CMD_RD_STATUS = 4'h3,
      CMD_RD_FLAGS = 4'h4,
      CMD_WR_STATUS = 4'h5,
      CMD_CLR_FLAGS = 4'h6,
      CMD_PROGRAM = 4'h7,
      CMD_ERASE_4K = 4'h8,
      CMD_ERASE_32K = 4'h9,
      CMD_ERASE_64K = 4'hA,
      CMD_BULK_ERASE = 4'hB
   } fsp_cmd_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'h0,
      ST_BUSY = 1'h1
   } fsp_state_t;

   typedef struct packed {
      fsp_cmd_t cmd;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } fsp_req_t;
endpackage

/* File: fsp_status_protect.sv */
// Status register, write-enable latch and block protection of a serial flash.
// Assumes a command decoder on linkClk hands over decoded commands one at a time
// and waits for rspValid; the write-protect pin is asynchronous to both clocks.
`timescale 1ns/1ns
module fsp_status_protect
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic linkClk,
   input wire logic wpPin_n,
   input wire logic reqValid,
   input wire fsp_pkg::fsp_req_t req,
   output logic reqReady,
   output logic rspValid,
   output logic [7:0] rspStatus,
   output logic [7:0] rspFlags,
   output logic opStart,
   output fsp_pkg::fsp_cmd_t opKind,
   output logic [fsp_pkg::ADDR_W-1:0] opAddr,
   output logic [11:0] opSector,
   output logic [12:0] opSub32,
   output logic [15:0] opSub4,
   output logic busy
);
   typedef struct packed {
      logic wpMeta, wpSync, reqMeta, reqSync, reqSeen, ackTgl;
      logic srwd, tb;
      logic [3:0] bp;
      logic wel, protErr;
      fsp_pkg::fsp_state_t state;
      logic [fsp_pkg::CNT_W-1:0] count;
      logic [7:0] snapStatus;
      logic [7:0] snapFlags;
      logic opStart;
      fsp_pkg::fsp_cmd_t opKind;
      logic [fsp_pkg::ADDR_W-1:0] opAddr;
   } fsp_core_t;

   typedef struct packed {
      logic reqTgl, pending;
      fsp_pkg::fsp_req_t held;
      logic ackMeta, ackSync, ackSeen, rspValid;
      logic [7:0] rspStatus;
      logic [7:0] rspFlags;
   } fsp_link_t;

   fsp_core_t core_ff;
   fsp_core_t nxt_core;
   fsp_link_t lnk_ff;
   fsp_link_t nxt_lnk;
   logic lrstMeta_ff;
   logic lrstSync_ff;

   // Decides whether a sector lies in the region that the protect code guards.
   function automatic logic fsp_is_protected(input logic tb, input logic [3:0] bp,
                                             input logic [11:0] sector);
      logic [12:0] span;
      logic hit;
      span = 13'h0000;
      hit = 1'h0;
      if (bp >= fsp_pkg::BP_ALL_FIRST)
      begin
         hit = 1'h1;
      end
      else if (tb)
      begin
         if (bp != fsp_pkg::BP_ZERO)
         begin
            span = 13'h0001 << (bp - fsp_pkg::BP_ONE);
            hit = {1'h0, sector} < span;
         end
      end
      else if (bp >= fsp_pkg::BP_TOP_FIRST)
      begin
         span = fsp_pkg::TOP_BASE_SPAN << (bp - fsp_pkg::BP_TOP_FIRST);
         hit = {1'h0, sector} >= (fsp_pkg::SECTOR_COUNT - span);
      end
      return hit;
   endfunction

   // Status and flag bytes as seen by a read.
   function automatic logic [7:0] fsp_status_byte(input fsp_core_t c);
      logic [7:0] b;
      b = 8'h00;
      b[fsp_pkg::SR_WD_BIT] = c.srwd;
      b[fsp_pkg::SR_BP3_BIT] = c.bp[3];
      b[fsp_pkg::SR_TB_BIT] = c.tb;
      b[fsp_pkg::SR_BPLO_MSB:fsp_pkg::SR_BPLO_LSB] = c.bp[2:0];
      b[fsp_pkg::SR_WEL_BIT] = c.wel;
      b[fsp_pkg::SR_WIP_BIT] = (c.state == fsp_pkg::ST_BUSY);
      return b;
   endfunction

   function automatic logic [7:0] fsp_flag_byte(input fsp_core_t c);
      logic [7:0] b;
      b = 8'h00;
      b[fsp_pkg::FL_READY_BIT] = (c.state != fsp_pkg::ST_BUSY);
      b[fsp_pkg::FL_PROT_BIT] = c.protErr;
      return b;
   endfunction

   // Core domain. The held request is stable whenever the toggle says new.
   logic newReq;
   logic wpLow;
   logic [11:0] reqSector;
   assign newReq = core_ff.reqSync != core_ff.reqSeen;
   assign wpLow = !core_ff.wpSync;
   assign reqSector = lnk_ff.held.addr[fsp_pkg::SECTOR_MSB:fsp_pkg::SECTOR_LSB];

   always_comb
   begin
      nxt_core = core_ff;
      nxt_core.wpMeta = wpPin_n;
      nxt_core.wpSync = core_ff.wpMeta;
      nxt_core.reqMeta = lnk_ff.reqTgl;
      nxt_core.reqSync = core_ff.reqMeta;
      nxt_core.opStart = 1'h0;
      case (core_ff.state)
         fsp_pkg::ST_BUSY:
         begin
            if (core_ff.count == '0)
            begin
               nxt_core.state = fsp_pkg::ST_IDLE;
               nxt_core.wel = 1'h0;
            end
            else
            begin
               nxt_core.count = core_ff.count - 1'h1;
            end
         end
         default:
         begin
            nxt_core.state = fsp_pkg::ST_IDLE;
         end
      endcase
      // While busy only reads are served; other commands are answered but dropped.
      if (newReq && (core_ff.state == fsp_pkg::ST_IDLE))
      begin
         case (lnk_ff.held.cmd)
            fsp_pkg::CMD_WR_ENABLE:
            begin
               nxt_core.wel = 1'h1;
            end
            fsp_pkg::CMD_WR_DISABLE:
            begin
               nxt_core.wel = 1'h0;
            end
            fsp_pkg::CMD_CLR_FLAGS:
            begin
               nxt_core.protErr = 1'h0;
            end
            fsp_pkg::CMD_WR_STATUS:
            begin
               if (core_ff.wel && core_ff.srwd && wpLow)
               begin
                  nxt_core.wel = 1'h0;
               end
               else if (core_ff.wel)
               begin
                  nxt_core.srwd = lnk_ff.held.data[fsp_pkg::SR_WD_BIT];
                  nxt_core.tb = lnk_ff.held.data[fsp_pkg::SR_TB_BIT];
                  nxt_core.bp = {lnk_ff.held.data[fsp_pkg::SR_BP3_BIT],
                     lnk_ff.held.data[fsp_pkg::SR_BPLO_MSB:fsp_pkg::SR_BPLO_LSB]};
                  nxt_core.state = fsp_pkg::ST_BUSY;
                  nxt_core.count = fsp_pkg::CNT_W'(fsp_pkg::STATUS_WRITE_CYC - 1);
               end
            end
            // No page erase exists; the 4KB subsector is the finest erase.
            fsp_pkg::CMD_PROGRAM, fsp_pkg::CMD_ERASE_4K, fsp_pkg::CMD_ERASE_32K,
            fsp_pkg::CMD_ERASE_64K, fsp_pkg::CMD_BULK_ERASE:
            begin
               if (core_ff.wel)
               begin
                  if ((lnk_ff.held.cmd == fsp_pkg::CMD_BULK_ERASE)
                      ? (core_ff.bp != fsp_pkg::BP_ZERO)
                      : fsp_is_protected(core_ff.tb, core_ff.bp, reqSector))
                  begin
                     nxt_core.protErr = 1'h1;
                     nxt_core.wel = 1'h0;
                  end
                  else
                  begin
                     nxt_core.opStart = 1'h1;
                     nxt_core.opKind = lnk_ff.held.cmd;
                     nxt_core.opAddr = lnk_ff.held.addr;
                     nxt_core.state = fsp_pkg::ST_BUSY;
                     nxt_core.count = (lnk_ff.held.cmd == fsp_pkg::CMD_PROGRAM)
                        ? fsp_pkg::CNT_W'(fsp_pkg::PROGRAM_CYC - 1)
                        : fsp_pkg::CNT_W'(fsp_pkg::ERASE_CYC - 1);
                  end
               end
            end
            default:
            begin
               nxt_core.srwd = core_ff.srwd;
            end
         endcase
      end
      if (newReq)
      begin
         nxt_core.reqSeen = core_ff.reqSync;
         nxt_core.ackTgl = !core_ff.ackTgl;
         nxt_core.snapStatus = fsp_status_byte(nxt_core);
         nxt_core.snapFlags = fsp_flag_byte(nxt_core);
      end
   end

   // Nonvolatile bits take their shipped defaults at reset, standing in for power-up.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         core_ff <= '0;
         core_ff.srwd <= fsp_pkg::SR_WD_RST;
         core_ff.tb <= fsp_pkg::SR_TB_RST;
         core_ff.bp <= fsp_pkg::BP_RST;
         core_ff.wpMeta <= 1'h1;
         core_ff.wpSync <= 1'h1;
      end
      else
      begin
         core_ff <= nxt_core;
      end
   end

   // Link domain: one request in flight, answered by a toggle back.
   always_ff @(posedge linkClk)
   begin
      lrstMeta_ff <= reset;
      lrstSync_ff <= lrstMeta_ff;
   end

   always_comb
   begin
      nxt_lnk = lnk_ff;
      nxt_lnk.ackMeta = core_ff.ackTgl;
      nxt_lnk.ackSync = lnk_ff.ackMeta;
      nxt_lnk.rspValid = 1'h0;
      if (reqValid && !lnk_ff.pending)
      begin
         nxt_lnk.held = req;
         nxt_lnk.reqTgl = !lnk_ff.reqTgl;
         nxt_lnk.pending = 1'h1;
      end
      if (lnk_ff.ackSync != lnk_ff.ackSeen)
      begin
         nxt_lnk.ackSeen = lnk_ff.ackSync;
         nxt_lnk.pending = 1'h0;
         nxt_lnk.rspValid = 1'h1;
         nxt_lnk.rspStatus = core_ff.snapStatus;
         nxt_lnk.rspFlags = core_ff.snapFlags;
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (lrstSync_ff)
      begin
         lnk_ff <= '0;
      end
      else
      begin
         lnk_ff <= nxt_lnk;
      end
   end

   assign reqReady = !lnk_ff.pending;
   assign rspValid = lnk_ff.rspValid;
   assign rspStatus = lnk_ff.rspStatus;
   assign rspFlags = lnk_ff.rspFlags;
   assign opStart = core_ff.opStart;
   assign opKind = core_ff.opKind;
   assign opAddr = core_ff.opAddr;
   assign opSector = core_ff.opAddr[fsp_pkg::SECTOR_MSB:fsp_pkg::SECTOR_LSB];
   assign opSub32 = core_ff.opAddr[fsp_pkg::SECTOR_MSB:fsp_pkg::SUB32_LSB];
   assign opSub4 = core_ff.opAddr[fsp_pkg::SECTOR_MSB:fsp_pkg::SUB4_LSB];
   assign busy = core_ff.state == fsp_pkg::ST_BUSY;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   logic accIdle;
   assign accIdle = newReq && !busy;

   AST_WRSR_LOCKED: assert property (accIdle && lnk_ff.held.cmd == fsp_pkg::CMD_WR_STATUS
      && core_ff.srwd && wpLow |=> $stable({core_ff.srwd, core_ff.tb, core_ff.bp}) && !busy)
      else $error("status write executed while hardware locked");
   AST_LOCK_HOLDS: assert property (core_ff.srwd && wpLow |=> core_ff.srwd)
      else $error("locked disable bit was released without the pin");
   AST_RESET_DEFAULT: assert property (@(posedge mclk) disable iff (1'h0)
      $past(reset) |-> core_ff.srwd && core_ff.tb && core_ff.bp == fsp_pkg::BP_RST)
      else $error("nonvolatile defaults wrong after reset");
   AST_PROT_REFUSE: assert property (accIdle && core_ff.wel
      && lnk_ff.held.cmd == fsp_pkg::CMD_PROGRAM
      && fsp_is_protected(core_ff.tb, core_ff.bp, reqSector)
      |=> !opStart && core_ff.protErr && !core_ff.wel && !busy)
      else $error("program in protected sector was not refused");
   AST_BULK_CLEAR: assert property (opStart && opKind == fsp_pkg::CMD_BULK_ERASE
      |-> core_ff.bp == fsp_pkg::BP_ZERO && $past(core_ff.wel))
      else $error("bulk erase started with a protect code set");
   AST_WEL_NEEDED: assert property ($rose(busy) |-> $past(core_ff.wel))
      else $error("write cycle began without the write-enable latch");
   AST_BUSY_HOLD: assert property (opStart |-> busy [*8])
      else $error("busy dropped right after an array operation began");
   AST_READY_INVERSE: assert property ($past(newReq)
      |-> core_ff.snapStatus[fsp_pkg::SR_WIP_BIT] != core_ff.snapFlags[fsp_pkg::FL_READY_BIT])
      else $error("busy bit is not the inverse of ready");
   AST_PROT_STICKY: assert property (core_ff.protErr
      && !(accIdle && lnk_ff.held.cmd == fsp_pkg::CMD_CLR_FLAGS) |=> core_ff.protErr)
      else $error("protection flag fell without a clear");
   AST_WEL_AUTOCLR: assert property ($fell(busy) |-> !core_ff.wel)
      else $error("write-enable latch survived a finished cycle");

   CVR_BULK: cover property (opStart && opKind == fsp_pkg::CMD_BULK_ERASE);
   CVR_PROT: cover property ($rose(core_ff.protErr));
   CVR_LOCKED: cover property (accIdle && lnk_ff.held.cmd == fsp_pkg::CMD_WR_STATUS
      && core_ff.srwd && wpLow && core_ff.wel);
   CVR_DONE: cover property ($fell(busy));
endmodule

/* File: fsp_host_model.sv */
// Host controller model that offers decoded commands on the link side.
// Assumes the bench calls send from one process, one command at a time.
`timescale 1ns/1ns
module fsp_host_model
(
   input wire logic linkClk,
   input wire logic reqReady,
   input wire logic rspValid,
   output logic reqValid,
   output fsp_pkg::fsp_req_t req
);
   initial
   begin
      reqValid = 1'h0;
      req = '0;
   end

   // Only one request is outstanding; the caller orders latch-setting commands first.
   task automatic send(input fsp_pkg::fsp_req_t r, input int gap);
      int n;
      n = 0;
      @(negedge linkClk);
      while (reqReady !== 1'h1 && n < 100)
      begin
         n++;
         @(negedge linkClk);
      end
      reqValid <= 1'h1;
      req <= r;
      @(negedge linkClk);
      reqValid <= 1'h0;
      // Released fields are inverted so a stale sample never matches the command sent.
      req <= fsp_pkg::fsp_req_t'(~r);
      n = 0;
      while (rspValid !== 1'h1 && n < 100)
      begin
         n++;
         @(negedge linkClk);
      end
      repeat (gap) @(negedge linkClk);
   endtask
endmodule

/* File: fsp_status_protect_tb.sv */
// Self-checking bench for the status register and block-protect logic.
// Assumes the host model on the link side; expected answers queue in issue order.
`timescale 1ns/1ns
module fsp_status_protect_tb;
   logic mclk, reset, linkClk, wpPin_n, reqValid, reqReady, rspValid, opStart, busy;
   fsp_pkg::fsp_req_t req;
   logic [7:0] rspStatus, rspFlags;
   int fails, comparisons, seed, starts, expStarts, i, j;
   logic srwdE, tbE, welE, wipE, protE;
   logic [3:0] bpE;
   logic [12:0] sp, s;
   logic [15:0] note;
   logic [15:0] expQ[$];
   fsp_pkg::fsp_cmd_t opKind;
   logic [27:0] opAddr;
   logic [11:0] opSector;
   logic [12:0] opSub32;
   logic [15:0] opSub4;
   logic [31:0] opNote;
   logic [31:0] opQ[$];

   fsp_status_protect i_dut
   (
      .mclk(mclk), .reset(reset), .linkClk(linkClk), .wpPin_n(wpPin_n),
      .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
      .rspStatus(rspStatus), .rspFlags(rspFlags), .opStart(opStart), .opKind(opKind),
      .opAddr(opAddr), .opSector(opSector), .opSub32(opSub32), .opSub4(opSub4), .busy(busy)
   );
   fsp_host_model i_host
   (
      .linkClk(linkClk), .reqReady(reqReady), .rspValid(rspValid),
      .reqValid(reqValid), .req(req)
   );

   initial
   begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      linkClk = 1'h0;
      #1;
      forever
      begin
         linkClk = ~linkClk;
         #24;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("Counts: comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [12:0] spanOf(input logic t, input logic [3:0] b);
      if (b >= 4'hD)
         return 13'h1000;
      if (t)
         return (b == 4'h0) ? 13'h0000 : 13'h0001 << (b - 4'h1);
      return (b < 4'h4) ? 13'h0000 : 13'h0008 << (b - 4'h4);
   endfunction

   function automatic logic isProt(input logic [11:0] sec);
      logic [12:0] w;
      w = spanOf(tbE, bpE);
      return tbE ? ({1'h0, sec} < w) : ({1'h0, sec} >= 13'h1000 - w);
   endfunction

   // Updates the expected state, notes the answer and hands the command to the host.
   task automatic cmd(input fsp_pkg::fsp_cmd_t c, input logic [27:0] a, input logic [7:0] d);
      logic prot;
      prot = (c == fsp_pkg::CMD_BULK_ERASE) ? (bpE != 4'h0) : isProt(a[27:16]);
      if (c == fsp_pkg::CMD_WR_ENABLE)
         welE = 1'h1;
      else if (c == fsp_pkg::CMD_WR_DISABLE)
         welE = 1'h0;
      else if (c == fsp_pkg::CMD_CLR_FLAGS)
         protE = 1'h0;
      else if (c == fsp_pkg::CMD_WR_STATUS && welE && srwdE && !wpPin_n)
         welE = 1'h0;
      else if (c == fsp_pkg::CMD_WR_STATUS && welE)
      begin
         {srwdE, bpE[3], tbE, bpE[2:0]} = d[7:2];
         wipE = 1'h1;
      end
      else if (c >= fsp_pkg::CMD_PROGRAM && welE && prot)
      begin
         protE = 1'h1;
         welE = 1'h0;
      end
      else if (c >= fsp_pkg::CMD_PROGRAM && welE)
      begin
         wipE = 1'h1;
         expStarts++;
         opQ.push_back({c, a});
      end
      expQ.push_back({srwdE, bpE[3], tbE, bpE[2:0], welE, wipE, ~wipE, 5'h00, protE, 1'h0});
      i_host.send('{c, a, d}, $random(seed) & 3);
   endtask

   // Waits out a write cycle; the latch drops when it completes.
   task automatic settle();
      int n;
      n = 0;
      @(negedge mclk);
      check({7'h00, busy}, {7'h00, wipE});
      while (wipE && busy !== 1'h0 && n < 3000)
      begin
         @(negedge mclk);
         n++;
      end
      check({7'h00, busy}, 8'h00);
      if (wipE)
         welE = 1'h0;
      wipE = 1'h0;
   endtask

   // Sampled mid-cycle so the one-cycle answer pulse is never raced at its launch edge.
   always @(negedge linkClk)
      if (rspValid === 1'h1)
      begin
         note = expQ.pop_front();
         check(rspStatus, note[15:8]);
         check(rspFlags, note[7:0]);
         check({7'h00, reqReady}, 8'h01);
      end

   always @(negedge mclk)
      if (opStart === 1'h1)
      begin
         starts++;
         if (opQ.size() > 0)
         begin
            opNote = opQ.pop_front();
            check(opKind, opNote[31:28]);
            check(opAddr, opNote[27:0]);
            check(opSector, opNote[27:16]);
            check(opSub32, opNote[27:15]);
            check(opSub4, opNote[27:12]);
         end
      end

   initial
   begin
      #800000;
      fails++;
      end_of_test();
   end

   initial
   begin
      seed = 32'h4868cb0d;
      reset = 1'h1;
      wpPin_n = 1'h0;
      fails = 0;
      comparisons = 0;
      starts = 0;
      expStarts = 0;
      {srwdE, tbE, bpE, welE, wipE, protE} = {1'h1, 1'h1, 4'h0, 3'h0};
      repeat (12) @(negedge mclk);
      reset <= 1'h0;
      repeat (3) @(posedge linkClk);
      cmd(fsp_pkg::CMD_RD_STATUS, 28'h0000000, 8'h00);
      cmd(fsp_pkg::CMD_PROGRAM, 28'h0000000, 8'h5A);
      cmd(fsp_pkg::CMD_WR_ENABLE, 28'h0000000, 8'h00);
      cmd(fsp_pkg::CMD_WR_DISABLE, 28'h0000000, 8'h00);
      cmd(fsp_pkg::CMD_ERASE_4K, 28'h0001000, 8'h00);
      settle();
      $display("test latch_and_defaults done");
      // The pin alternates so the locked state is entered, left, entered and left again.
      for (i = 0; i < 4; i++)
      begin
         @(negedge mclk);
         wpPin_n <= i[0];
         repeat (4) @(negedge mclk);
         cmd(fsp_pkg::CMD_WR_ENABLE, 28'h0000000, 8'h00);
         cmd(fsp_pkg::CMD_WR_STATUS, 28'h0000000, (i == 3) ? 8'h20 : 8'hA4);
         settle();
      end
      $display("test hardware_lock done");
      // Every code in both anchorings, probed on each side of the region edge, or at the first and last sectors where the region is empty or whole.
      for (i = 0; i < 32; i++)
      begin
         @(negedge mclk);
         wpPin_n <= 1'($random(seed));
         repeat (4) @(negedge mclk);
         cmd(fsp_pkg::CMD_WR_ENABLE, 28'h0000000, 8'h00);
         cmd(fsp_pkg::CMD_WR_STATUS, 28'h0000000, {1'h0, i[3], i[4], i[2:0], 2'h0});
         settle();
         sp = spanOf(tbE, bpE);
         for (j = 0; j < 2; j++)
         begin
            s = tbE ? (sp - 13'(1 - j)) : (13'h1000 - sp - 13'(j));
            cmd(fsp_pkg::CMD_WR_ENABLE, 28'h0000000, 8'h00);
            // The second probe of the first four codes walks program and the 4K, 32K and 64K erases.
            cmd(fsp_pkg::fsp_cmd_t'(4'h7 + (isProt(s[11:0]) ? 4'($random(seed) & 3) :
               (j == 1 && i < 4) ? 4'(i) : 4'h0)),
               {s[11:0], 16'($random(seed))}, 8'($random(seed)));
            if (wipE)
               cmd(fsp_pkg::CMD_RD_FLAGS, 28'h0000000, 8'h00);
            settle();
         end
         cmd(fsp_pkg::CMD_WR_ENABLE, 28'h0000000, 8'h00);
         cmd(fsp_pkg::CMD_BULK_ERASE, 28'h0000000, 8'h00);
         settle();
         cmd(fsp_pkg::CMD_CLR_FLAGS, 28'h0000000, 8'h00);
      end
      $display("test protect_table done");
      repeat (20) @(negedge linkClk);
      check(starts, expStarts);
      check(expQ.size(), 0);
      check(opQ.size(), 0);
      end_of_test();
   end
endmodule
